// ===== design/rpcf_top.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Acknowledge bus clears pause requests only while wait-for-acknowledge is set.
// [R2] User logic acknowledges each pause request on its matching acknowledge bit.
// [R3] Global control frames are classified only while their enable is set.
// [R4] Global control multicast check compares destination with multicast pause address.
// [R5] Global control unicast check compares destination with unicast pause address.
// [R6] Global control source check compares source with pause source address.
// [R7] Global control ethertype check requires type equal to its configured value.
// [R8] Global control opcode check tests opcode against configured minimum and maximum.
// [R9] Priority control frames are classified only while their enable is set.
// [R10] Priority control multicast check compares destination with multicast address.
// [R11] Priority control unicast check compares destination with unicast address.
// [R12] Priority control source check compares source with pause source address.
// [R13] Priority control ethertype check requires type equal to its configured value.
// [R14] Priority control opcode check tests opcode against configured minimum and maximum.
// [R15] Global pause frames are classified only while their enable is set.
// [R16] Global pause multicast check compares destination with multicast address.
// [R17] Global pause unicast check compares destination with unicast address.
// [R18] Global pause source check compares source with pause source address.
// [R19] Global pause ethertype check requires type equal to its configured value.
// [R20] Global pause opcode check verifies the received opcode when switched on.
// [R21] Global pause opcode check compares against one configured opcode value.
// [R22] Accepted pause sets its request bit, held until the pause is processed.
// [R23] Standard pause frame raises valid bit 8 and fills quanta slot 8.
// [R24] Control frames are forwarded when forwarding is on, dropped otherwise.
// [R25] A class matches only when every switched-on check passes, with one hit enough for both address checks; off checks pass.
// [R26] Opcode range bounds are inclusive at both ends.
`include "rpcf_map.svh"
module rpcf_top
(
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_frm_valid,
    input  wire rpcf_pkg::rpcf_hdr_t    i_frm_hdr,
    input  wire logic                   i_wait_for_ack,
    input  wire rpcf_pkg::rpcf_slot_t   i_pause_ack,
    input  wire rpcf_pkg::rpcf_addr_t   i_pause_unicast_dest_addr,
    input  wire rpcf_pkg::rpcf_addr_t   i_pause_multicast_dest_addr,
    input  wire rpcf_pkg::rpcf_addr_t   i_pause_source_addr,
    input  wire logic                   i_glob_ctrl_enable,
    input  wire logic                   i_glob_ctrl_mcast_check,
    input  wire logic                   i_glob_ctrl_ucast_check,
    input  wire logic                   i_glob_ctrl_source_check,
    input  wire logic                   i_glob_ctrl_etype_check,
    input  wire rpcf_pkg::rpcf_field_t  i_glob_ctrl_etype,
    input  wire logic                   i_glob_ctrl_opcode_check,
    input  wire rpcf_pkg::rpcf_field_t  i_glob_ctrl_opcode_min,
    input  wire rpcf_pkg::rpcf_field_t  i_glob_ctrl_opcode_max,
    input  wire logic                   i_prio_ctrl_enable,
    input  wire logic                   i_prio_ctrl_mcast_check,
    input  wire logic                   i_prio_ctrl_ucast_check,
    input  wire logic                   i_prio_ctrl_source_check,
    input  wire logic                   i_prio_ctrl_etype_check,
    input  wire rpcf_pkg::rpcf_field_t  i_prio_ctrl_etype,
    input  wire logic                   i_prio_ctrl_opcode_check,
    input  wire rpcf_pkg::rpcf_field_t  i_prio_ctrl_opcode_min,
    input  wire rpcf_pkg::rpcf_field_t  i_prio_ctrl_opcode_max,
    input  wire logic                   i_glob_pause_enable,
    input  wire logic                   i_glob_pause_mcast_check,
    input  wire logic                   i_glob_pause_ucast_check,
    input  wire logic                   i_glob_pause_source_check,
    input  wire logic                   i_glob_pause_etype_check,
    input  wire rpcf_pkg::rpcf_field_t  i_glob_pause_etype,
    input  wire logic                   i_glob_pause_opcode_check,
    input  wire rpcf_pkg::rpcf_field_t  i_glob_pause_opcode,
    input  wire logic                   i_forward_control,
    output logic                        o_pause_valid_any,
    output rpcf_pkg::rpcf_slot_t        o_pause_valid,
    output rpcf_pkg::rpcf_quanta_t      o_pause_quanta,
    output rpcf_pkg::rpcf_slot_t        o_pause_req,
    output rpcf_pkg::rpcf_class_t       o_frm_class,
    output logic                        o_ctrl_forward,
    output logic                        o_ctrl_drop
);
    import rpcf_pkg::*;

    rpcf_class_sw_t sw_gcp;
    rpcf_class_sw_t sw_pcp;
    rpcf_class_sw_t sw_gpp;

    assign sw_gcp = '{enable:       i_glob_ctrl_enable,
                      mcast_check:  i_glob_ctrl_mcast_check,
                      ucast_check:  i_glob_ctrl_ucast_check,
                      source_check: i_glob_ctrl_source_check,
                      etype_check:  i_glob_ctrl_etype_check,
                      opcode_check: i_glob_ctrl_opcode_check};
    assign sw_pcp = '{enable:       i_prio_ctrl_enable,
                      mcast_check:  i_prio_ctrl_mcast_check,
                      ucast_check:  i_prio_ctrl_ucast_check,
                      source_check: i_prio_ctrl_source_check,
                      etype_check:  i_prio_ctrl_etype_check,
                      opcode_check: i_prio_ctrl_opcode_check};
    assign sw_gpp = '{enable:       i_glob_pause_enable,
                      mcast_check:  i_glob_pause_mcast_check,
                      ucast_check:  i_glob_pause_ucast_check,
                      source_check: i_glob_pause_source_check,
                      etype_check:  i_glob_pause_etype_check,
                      opcode_check: i_glob_pause_opcode_check};

    // Shared field comparators
    logic da_is_mcast;
    logic da_is_ucast;
    logic sa_is_pause;
    logic frm_take;

    assign frm_take    = i_frm_valid && i_frm_hdr.good;
    assign da_is_mcast = (i_frm_hdr.dest_addr == i_pause_multicast_dest_addr);
    assign da_is_ucast = (i_frm_hdr.dest_addr == i_pause_unicast_dest_addr);
    assign sa_is_pause = (i_frm_hdr.src_addr == i_pause_source_addr);

    // Destination passes when any switched-on address check hits;
    // both on means either address is accepted, and one hit is enough.
    function automatic logic dest_pass(input rpcf_class_sw_t sw,
                                       input logic mc_hit,
                                       input logic uc_hit);
        logic any_on;
        any_on    = sw.mcast_check || sw.ucast_check;
        dest_pass = !any_on || (sw.mcast_check && mc_hit) || (sw.ucast_check && uc_hit);
    endfunction

    // Global control class
    logic gcp_dest_ok;
    logic gcp_src_ok;
    logic gcp_etype_ok;
    logic gcp_op_in_range;
    logic gcp_op_ok;
    logic gcp_match;

    assign gcp_dest_ok     = dest_pass(sw_gcp, da_is_mcast, da_is_ucast); // see [R4] [R5]
    assign gcp_src_ok      = !sw_gcp.source_check || sa_is_pause; // see [R6]
    assign gcp_etype_ok    = !sw_gcp.etype_check
                             || (i_frm_hdr.ethertype == i_glob_ctrl_etype); // see [R7]
    assign gcp_op_in_range = (i_frm_hdr.opcode >= i_glob_ctrl_opcode_min)
                             && (i_frm_hdr.opcode <= i_glob_ctrl_opcode_max); // see [R26]
    assign gcp_op_ok       = !sw_gcp.opcode_check || gcp_op_in_range; // see [R8]
    assign gcp_match       = sw_gcp.enable && gcp_dest_ok && gcp_src_ok
                             && gcp_etype_ok && gcp_op_ok; // see [R3] [R25]

    // Priority control class
    logic pcp_dest_ok;
    logic pcp_src_ok;
    logic pcp_etype_ok;
    logic pcp_op_in_range;
    logic pcp_op_ok;
    logic pcp_match;

    assign pcp_dest_ok     = dest_pass(sw_pcp, da_is_mcast, da_is_ucast); // see [R10] [R11]
    assign pcp_src_ok      = !sw_pcp.source_check || sa_is_pause; // see [R12]
    assign pcp_etype_ok    = !sw_pcp.etype_check
                             || (i_frm_hdr.ethertype == i_prio_ctrl_etype); // see [R13]
    assign pcp_op_in_range = (i_frm_hdr.opcode >= i_prio_ctrl_opcode_min)
                             && (i_frm_hdr.opcode <= i_prio_ctrl_opcode_max); // see [R26]
    assign pcp_op_ok       = !sw_pcp.opcode_check || pcp_op_in_range; // see [R14]
    assign pcp_match       = sw_pcp.enable && pcp_dest_ok && pcp_src_ok
                             && pcp_etype_ok && pcp_op_ok; // see [R9] [R25]

    // Global pause class
    logic gpp_dest_ok;
    logic gpp_src_ok;
    logic gpp_etype_ok;
    logic gpp_op_ok;
    logic gpp_match;

    assign gpp_dest_ok  = dest_pass(sw_gpp, da_is_mcast, da_is_ucast); // see [R16] [R17]
    assign gpp_src_ok   = !sw_gpp.source_check || sa_is_pause; // see [R18]
    assign gpp_etype_ok = !sw_gpp.etype_check
                          || (i_frm_hdr.ethertype == i_glob_pause_etype); // see [R19]
    assign gpp_op_ok    = !sw_gpp.opcode_check
                          || (i_frm_hdr.opcode == i_glob_pause_opcode); // see [R20] [R21]
    assign gpp_match    = sw_gpp.enable && gpp_dest_ok && gpp_src_ok
                          && gpp_etype_ok && gpp_op_ok; // see [R15] [R25]

    // Classification of the frame on the strobe
    rpcf_class_t class_now;
    logic        is_ctrl;

    assign class_now.glob_ctrl  = frm_take && gcp_match;
    assign class_now.prio_ctrl  = frm_take && pcp_match;
    assign class_now.glob_pause = frm_take && gpp_match;
    assign is_ctrl              = class_now.glob_ctrl || class_now.prio_ctrl
                                  || class_now.glob_pause;

    // Per-slot pause events and quanta
    rpcf_slot_t   pause_set;
    rpcf_quanta_t quanta_now;

    genvar g;
    generate
        for (g = 0; g < `RPCF_NUM_PRIO; g++)
        begin : g_prio
            assign pause_set[g]  = class_now.prio_ctrl && i_frm_hdr.prio_enable[g];
            assign quanta_now[g] = i_frm_hdr.quanta[g];
        end
    endgenerate

    // Standard pause carries its single quanta in the first field
    assign pause_set[`RPCF_GLOBAL_SLOT]  = class_now.glob_pause; // see [R23]
    assign quanta_now[`RPCF_GLOBAL_SLOT] = i_frm_hdr.quanta[0]; // see [R23]

    // Request hold; a fresh pause wins over an acknowledge in the same cycle.
    // Without wait-for-acknowledge the request lasts one cycle, as processing
    // is then assumed to happen at once.
    rpcf_slot_t req_reg;
    rpcf_slot_t req_next;
    rpcf_slot_t req_clear;

    assign req_clear = i_wait_for_ack ? i_pause_ack : `RPCF_ALL_SLOTS; // see [R1] [R2]
    assign req_next  = pause_set | (req_reg & ~req_clear); // see [R22]

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            req_reg <= `RPCF_SLOT_RST;
        else
            req_reg <= req_next;
    end

    // Valid strobes, one cycle after the header
    rpcf_slot_t valid_reg;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            valid_reg <= `RPCF_SLOT_RST;
        else
            valid_reg <= pause_set; // see [R23]
    end

    // Quanta slots load only on their own event, so older values persist
    rpcf_quanta_t quanta_reg;

    generate
        for (g = 0; g < `RPCF_NUM_SLOT; g++)
        begin : g_quanta
            always_ff @(posedge i_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                    quanta_reg[g] <= `RPCF_QUANTA_RST;
                else if (pause_set[g])
                    quanta_reg[g] <= quanta_now[g];
            end
        end
    endgenerate

    // Class flags and forwarding decision
    rpcf_class_t class_reg;
    logic        fwd_reg;
    logic        drop_reg;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            class_reg <= '0;
        else
            class_reg <= class_now;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            fwd_reg  <= 1'b0;
            drop_reg <= 1'b0;
        end
        else
        begin
            fwd_reg  <= is_ctrl && i_forward_control; // see [R24]
            drop_reg <= is_ctrl && !i_forward_control; // see [R24]
        end
    end

    assign o_pause_valid     = valid_reg;
    assign o_pause_valid_any = |valid_reg;
    assign o_pause_quanta    = quanta_reg;
    assign o_pause_req       = req_reg;
    assign o_frm_class       = class_reg;
    assign o_ctrl_forward    = fwd_reg;
    assign o_ctrl_drop       = drop_reg;

endmodule

// ===== pkg/rpcf_map.svh
`ifndef RPCF_MAP_SVH
`define RPCF_MAP_SVH

// Slot layout of the pause request, valid and quanta buses
`define RPCF_NUM_PRIO       8
`define RPCF_NUM_SLOT       9
`define RPCF_GLOBAL_SLOT    8

// Field widths
`define RPCF_ADDR_W         48
`define RPCF_FIELD_W        16

// Reset values and the all-slots clear mask
`define RPCF_SLOT_RST       9'h000
`define RPCF_QUANTA_RST     16'h0000
`define RPCF_ALL_SLOTS      9'h1FF

// Latency from header strobe to registered outputs, in clock cycles
`define RPCF_LATENCY        1

`endif

// ===== pkg/rpcf_pkg.sv
package rpcf_pkg;

    `include "rpcf_map.svh"

    typedef logic [`RPCF_ADDR_W-1:0]  rpcf_addr_t;
    typedef logic [`RPCF_FIELD_W-1:0] rpcf_field_t;
    typedef logic [`RPCF_NUM_SLOT-1:0] rpcf_slot_t;

    // Parsed header of one received frame, presented for one cycle
    typedef struct packed {
        logic                                        good;
        rpcf_addr_t                                  dest_addr;
        rpcf_addr_t                                  src_addr;
        rpcf_field_t                                 ethertype;
        rpcf_field_t                                 opcode;
        logic [`RPCF_NUM_PRIO-1:0]                   prio_enable;
        logic [`RPCF_NUM_PRIO-1:0][`RPCF_FIELD_W-1:0] quanta;
    } rpcf_hdr_t;

    // Check switches of one frame class
    typedef struct packed {
        logic enable;
        logic mcast_check;
        logic ucast_check;
        logic source_check;
        logic etype_check;
        logic opcode_check;
    } rpcf_class_sw_t;

    // Classification result of one frame
    typedef struct packed {
        logic glob_ctrl;
        logic prio_ctrl;
        logic glob_pause;
    } rpcf_class_t;

    typedef logic [`RPCF_NUM_SLOT-1:0][`RPCF_FIELD_W-1:0] rpcf_quanta_t;

endpackage

// ===== verification/rpcf_top_asserts.sv
`timescale 1ns/1ps
module rpcf_top_asserts
(
    input wire logic                   i_clk,
    input wire logic                   i_sys_rst,
    input wire logic                   i_frm_valid,
    input wire rpcf_pkg::rpcf_hdr_t    i_frm_hdr,
    input wire logic                   i_wait_for_ack,
    input wire rpcf_pkg::rpcf_slot_t   i_pause_ack,
    input wire logic                   i_glob_ctrl_enable,
    input wire logic                   i_prio_ctrl_enable,
    input wire logic                   i_glob_pause_enable,
    input wire logic                   i_forward_control,
    input wire rpcf_pkg::rpcf_slot_t   o_pause_valid,
    input wire rpcf_pkg::rpcf_quanta_t o_pause_quanta,
    input wire rpcf_pkg::rpcf_slot_t   o_pause_req,
    input wire rpcf_pkg::rpcf_class_t  o_frm_class,
    input wire logic                   o_ctrl_forward,
    input wire logic                   o_ctrl_drop
);
    import rpcf_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_unacked;
        i_wait_for_ack && o_pause_req[8] && !i_pause_ack[8];
    endsequence
    gc_off_a: assert property (!i_glob_ctrl_enable |=> !o_frm_class.glob_ctrl)
        else $error("glob ctrl class while disabled");
    pc_off_a: assert property (!i_prio_ctrl_enable |=> !o_frm_class.prio_ctrl)
        else $error("prio ctrl class while disabled");
    gp_off_a: assert property (!i_glob_pause_enable |=> !o_frm_class.glob_pause)
        else $error("glob pause class while disabled");
    gp_slot_a: assert property (o_frm_class.glob_pause |-> o_pause_valid[8]
        && o_pause_quanta[8] == $past(i_frm_hdr.quanta[0])) else $error("slot 8 wrong");
    req_hold_a: assert property (s_unacked |=> o_pause_req[8])
        else $error("request dropped without ack");
    ack_clear_a: assert property (i_wait_for_ack && i_pause_ack[8] && !i_frm_valid
        |=> !o_pause_req[8]) else $error("ack did not clear request");
    req_pulse_a: assert property (!i_wait_for_ack && !i_frm_valid
        |=> o_pause_req == 9'h000) else $error("request held without wait");
    fwd_sel_a: assert property (|o_frm_class |->
        (o_ctrl_forward == $past(i_forward_control)) && (o_ctrl_drop != o_ctrl_forward))
        else $error("forward or drop wrong");
    no_frame_a: assert property (!i_frm_valid |=> o_frm_class == 3'h0 && !o_ctrl_drop)
        else $error("class without frame");
endmodule
bind rpcf_top rpcf_top_asserts i_rpcf_top_asserts
(
    .i_clk, .i_sys_rst, .i_frm_valid, .i_frm_hdr, .i_wait_for_ack, .i_pause_ack,
    .i_glob_ctrl_enable, .i_prio_ctrl_enable, .i_glob_pause_enable, .i_forward_control,
    .o_pause_valid, .o_pause_quanta, .o_pause_req, .o_frm_class, .o_ctrl_forward, .o_ctrl_drop
);

// ===== verification/rpcf_user_model.sv
`timescale 1ns/1ps
module rpcf_user_model
(
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_slow,
    input  wire rpcf_pkg::rpcf_slot_t i_pause_req,
    output rpcf_pkg::rpcf_slot_t      o_pause_ack
);
    import rpcf_pkg::*;
    rpcf_slot_t seen1_reg, seen2_reg, ack_reg;
    assign o_pause_ack = ack_reg;
    // Slow mode notes a request two cycles later; ack is a one-cycle pulse
    // so a request raised again right after is never acked unseen
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            seen1_reg <= 9'h000;
            seen2_reg <= 9'h000;
            ack_reg   <= 9'h000;
        end
        else
        begin
            seen1_reg <= i_pause_req;
            seen2_reg <= seen1_reg & i_pause_req;
            ack_reg   <= (i_slow ? seen2_reg : seen1_reg) & i_pause_req & ~ack_reg;
        end
    end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rpcf_pkg::*;
    logic           i_clk, i_sys_rst, i_frm_valid, i_wait_for_ack, i_forward_control, slow;
    logic           o_pause_valid_any, o_ctrl_forward, o_ctrl_drop, gc, pc, gp;
    logic [2:0]     gc_lo, gc_hi, pc_lo, pc_hi, gp_op;
    logic [14:0]    e_flg, got_flg;
    rpcf_hdr_t      i_frm_hdr;
    rpcf_slot_t     i_pause_ack, o_pause_valid, o_pause_req, e_req, set;
    rpcf_addr_t     i_pause_unicast_dest_addr, i_pause_multicast_dest_addr, i_pause_source_addr;
    rpcf_class_sw_t gcs, pcs, gps;
    rpcf_class_t    o_frm_class;
    rpcf_quanta_t   o_pause_quanta, e_q;
    int             error_cnt = 0, n_checks = 0, seed;
    rpcf_top i_rpcf_top
    (
        .i_clk, .i_sys_rst, .i_frm_valid, .i_frm_hdr, .i_wait_for_ack, .i_pause_ack,
        .i_pause_unicast_dest_addr, .i_pause_multicast_dest_addr, .i_pause_source_addr,
        .i_glob_ctrl_enable(gcs.enable), .i_glob_ctrl_mcast_check(gcs.mcast_check),
        .i_glob_ctrl_ucast_check(gcs.ucast_check), .i_glob_ctrl_source_check(gcs.source_check),
        .i_glob_ctrl_etype_check(gcs.etype_check), .i_glob_ctrl_opcode_check(gcs.opcode_check),
        .i_glob_ctrl_etype(16'h8808), .i_glob_ctrl_opcode_min({13'h0000, gc_lo}),
        .i_glob_ctrl_opcode_max({13'h0000, gc_hi}), .i_prio_ctrl_enable(pcs.enable),
        .i_prio_ctrl_mcast_check(pcs.mcast_check), .i_prio_ctrl_ucast_check(pcs.ucast_check),
        .i_prio_ctrl_source_check(pcs.source_check), .i_prio_ctrl_etype_check(pcs.etype_check),
        .i_prio_ctrl_etype(16'h8808), .i_prio_ctrl_opcode_check(pcs.opcode_check),
        .i_prio_ctrl_opcode_min({13'h0000, pc_lo}), .i_prio_ctrl_opcode_max({13'h0000, pc_hi}),
        .i_glob_pause_enable(gps.enable), .i_glob_pause_mcast_check(gps.mcast_check),
        .i_glob_pause_ucast_check(gps.ucast_check), .i_glob_pause_source_check(gps.source_check),
        .i_glob_pause_etype_check(gps.etype_check), .i_glob_pause_etype(16'h8809),
        .i_glob_pause_opcode_check(gps.opcode_check), .i_glob_pause_opcode({13'h0000, gp_op}),
        .i_forward_control, .o_pause_valid_any, .o_pause_valid, .o_pause_quanta, .o_pause_req,
        .o_frm_class, .o_ctrl_forward, .o_ctrl_drop
    );
    rpcf_user_model i_rpcf_user_model
    (
        .i_clk, .i_sys_rst, .i_slow(slow), .i_pause_req(o_pause_req), .o_pause_ack(i_pause_ack)
    );
    assign got_flg = {o_frm_class, o_pause_valid, o_pause_valid_any, o_ctrl_forward, o_ctrl_drop};
    function automatic rpcf_addr_t pick(logic b);
        return b ? 48'h0123_4567_89AB : 48'h0123_4567_89AC;
    endfunction
    function automatic logic hit(rpcf_class_sw_t s, rpcf_field_t et, int lo, int hi);
        int op;
        op = i_frm_hdr.opcode;
        return i_frm_valid && i_frm_hdr.good && s.enable
            && ((!s.mcast_check && !s.ucast_check)
                || (s.mcast_check && i_frm_hdr.dest_addr == i_pause_multicast_dest_addr)
                || (s.ucast_check && i_frm_hdr.dest_addr == i_pause_unicast_dest_addr))
            && (!s.source_check || i_frm_hdr.src_addr == i_pause_source_addr)
            && (!s.etype_check || i_frm_hdr.ethertype == et)
            && (!s.opcode_check || (op >= lo && op <= hi));
    endfunction
    // Expected outputs one edge after the header is sampled
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            e_flg = 15'h0000;
            e_req = 9'h000;
            e_q = '0;
        end
        else
        begin
            gc = hit(gcs, 16'h8808, gc_lo, gc_hi);
            pc = hit(pcs, 16'h8808, pc_lo, pc_hi);
            gp = hit(gps, 16'h8809, gp_op, gp_op);
            set = {gp, pc ? i_frm_hdr.prio_enable : 8'h00};
            for (int k = 0; k < 9; k++)
                if (set[k])
                    e_q[k] = i_frm_hdr.quanta[k % 8];
            e_req = set | (i_wait_for_ack ? e_req & ~i_pause_ack : 9'h000);
            e_flg = {gc, pc, gp, set, |set, (gc | pc | gp) & i_forward_control,
                     (gc | pc | gp) & ~i_forward_control};
        end
    end
    task automatic chk(input logic [143:0] got, input logic [143:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    always @(negedge i_clk)
        if (i_sys_rst === 1'b0)
        begin
            chk(got_flg, e_flg, "class flags");
            chk(o_pause_req, e_req, "pause request");
            chk(o_pause_quanta, e_q, "pause quanta");
        end
    task automatic step();
        logic [31:0] r;
        r = $random(seed);
        {gcs, pcs, gps} = r[17:0];
        {gc_lo, gc_hi, pc_lo, pc_hi} = r[29:18];
        i_forward_control = r[30];
        r = $random(seed);
        gp_op = r[2:0];
        i_frm_hdr.opcode = {13'h0000, r[5:3]};
        i_frm_hdr.prio_enable = r[13:6];
        i_frm_valid = |r[15:14];
        i_frm_hdr.good = |r[17:16];
        i_frm_hdr.ethertype = r[18] ? 16'h8808 : 16'h8809;
        i_frm_hdr.dest_addr = pick(r[19]);
        i_frm_hdr.src_addr = pick(r[20]);
        i_pause_unicast_dest_addr = pick(r[21]);
        i_pause_multicast_dest_addr = pick(r[22]);
        i_pause_source_addr = pick(r[23]);
        i_frm_hdr.quanta = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial
    begin
        #50000;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        seed = 32'h37D62C7B;
        i_sys_rst = 1'b1;
        i_wait_for_ack = 1'b0;
        slow = 1'b0;
        step();
        repeat (2) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        // Phases cover both ack modes, prompt and slow user logic, and a mid-run reset
        for (int ph = 0; ph < 4; ph++)
        begin
            i_wait_for_ack = ph[0];
            slow = ph[1];
            for (int c = 0; c < 300; c++)
            begin
                @(posedge i_clk);
                #1;
                i_sys_rst = (ph == 2 && c >= 150 && c < 152);
                step();
            end
            $display("test %0d done", ph);
        end
        report_and_stop();
    end
endmodule
